/* File: src/cmu_dev.sv */
// configuration mode unlock port with index/data register window
// Notes on behaviour
// - strap latched once when reset ends
// - strap picks 3F0H or 370H port pair
// - two 55H index writes enter mode
// - any other write between breaks unlock
// - index picks register, data port accesses it
// - AAH to index leaves configuration mode
// - host keeps other writes out of unlock
// - registers hold defaults without any programming
// - index load needed before data access
// - registers survive hardware reset, power-up loads
`timescale 1ns/1ps
`default_nettype none
module cmu_dev
  import cmu_pkg::*;
(
  input  wire logic                     clk_sys,          // bus clock
  input  wire logic                     reset_n,          // hardware reset
  input  wire logic                     por_n,            // power-on reset
  input  wire logic                     config_base_strap, // base strap
  cmu_io_if.dev                         io,               // host i/o bus
  output logic [CMU_NREG-1:0][7:0]      cfg_image,        // register set
  output logic                          config_active,    // mode entered
  output logic                          base_is_alt       // 370H base
);

  // control state, cleared by hardware reset
  typedef struct packed {
    cmu_dev_state_type state;
    logic              strap_done;
    logic              alt_base;
    logic              cfg_mode;
    logic [7:0]        index;
    logic              index_ok;
    logic [7:0]        rdata;
    logic              rack;
  } cmu_dev_ctl_type;

  // register set, loaded with defaults only at power-up
  typedef logic [CMU_NREG-1:0][7:0] cmu_cfg_set_type;

  cmu_dev_ctl_type s_r;
  cmu_dev_ctl_type s_nxt;
  cmu_cfg_set_type cfg_r;
  cmu_cfg_set_type cfg_nxt;

  logic                idx_hit;
  logic                dat_hit;
  logic                reg_ok;
  logic                unlock_wr;
  logic                lock_wr;
  logic                data_wr;
  logic                data_rd;
  logic [CMU_NREG-1:0] cfg_we;

  // decode of one port of the pair, used for both ports
  function automatic logic port_hit(
    input logic [CMU_AW-1:0] addr,
    input logic              alt,
    input logic              data_port
  );
    logic [CMU_AW-1:0] want;
    want = 16'h0000;
    if (alt) begin
      want = data_port ? CMU_DATA_ALT : CMU_INDEX_ALT;
    end else begin
      want = data_port ? CMU_DATA_PRI : CMU_INDEX_PRI;
    end
    return addr == want;
  endfunction

  // index-port write carrying one given code; used for both codes
  function automatic logic code_write(
    input logic              wr,
    input logic              hit,
    input logic [CMU_DW-1:0] wdata,
    input logic [CMU_DW-1:0] code
  );
    return wr && hit && (wdata == code);
  endfunction

  // power-up image of the whole set
  function automatic cmu_cfg_set_type cfg_defaults();
    cmu_cfg_set_type v;
    v = '0;
    for (int i = 0; i < CMU_NREG; i++) begin
      v[i] = cmu_default(i);
    end
    return v;
  endfunction

  localparam cmu_cfg_set_type CMU_CFG_POR = cfg_defaults();

  // port decode; nothing is claimed until the strap is known
  always_comb begin
    idx_hit   = s_r.strap_done &&
                port_hit(io.io_addr, s_r.alt_base, 1'b0);
    dat_hit   = s_r.strap_done &&
                port_hit(io.io_addr, s_r.alt_base, 1'b1);
    // register numbers are checked once, here, for every access
    reg_ok    = s_r.index_ok && (s_r.index <= CMU_LAST_REG);
    unlock_wr = code_write(io.io_wr, idx_hit, io.io_wdata,
                           CMU_UNLOCK_CODE);
    lock_wr   = code_write(io.io_wr, idx_hit, io.io_wdata,
                           CMU_LOCK_CODE);
    // the register set is only reachable in configuration mode
    data_wr   = s_r.cfg_mode && io.io_wr && dat_hit && reg_ok;
    data_rd   = s_r.cfg_mode && io.io_rd && dat_hit;
  end

  // one write enable per register; an index past the set matches
  // none, so the array is never written out of range
  for (genvar g = 0; g < CMU_NREG; g++) begin : g_cfg_we
    assign cfg_we[g] = data_wr && (s_r.index == 8'(g));
  end

  // next-state logic of the unlock sequence and register window
  always_comb begin
    s_nxt      = s_r;
    cfg_nxt    = cfg_r;
    s_nxt.rack = 1'b0;

    // strap taken on the first edge after reset release only
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.alt_base   = config_base_strap;
    end

    unique case (s_r.state)
      CMU_LOCKED: begin
        // index writes are only unlock candidates here
        if (unlock_wr) begin
          s_nxt.state = CMU_ARMED;
        end
      end
      CMU_ARMED: begin
        // the very next write decides; reads do not disturb
        if (io.io_wr) begin
          if (unlock_wr) begin
            s_nxt.state    = CMU_CONFIG;
            s_nxt.cfg_mode = 1'b1;
            s_nxt.index_ok = 1'b0;
          end else begin
            // any other write, at any address, spoils the pair
            s_nxt.state = CMU_LOCKED;
          end
        end
      end
      CMU_CONFIG: begin
        // the lock code is never taken as a register number
        if (lock_wr) begin
          s_nxt.state    = CMU_LOCKED;
          s_nxt.cfg_mode = 1'b0;
          s_nxt.index_ok = 1'b0;
        end else if (io.io_wr && idx_hit) begin
          s_nxt.index    = io.io_wdata;
          s_nxt.index_ok = 1'b1;
        end
        // numbers past the last register are accepted but inert
        for (int i = 0; i < CMU_NREG; i++) begin
          if (cfg_we[i]) begin
            cfg_nxt[i] = io.io_wdata;
          end
        end
        // a read of the data port is answered on the next edge
        if (data_rd) begin
          s_nxt.rack  = 1'b1;
          s_nxt.rdata = reg_ok ? cfg_r[s_r.index[5:0]]
                               : CMU_FLOAT_DATA;
        end
      end
    endcase
  end

  // hardware reset: back to locked, strap relatched afterwards
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r.state      <= CMU_LOCKED;
      s_r.strap_done <= 1'b0;
      s_r.alt_base   <= 1'b0;
      s_r.cfg_mode   <= 1'b0;
      s_r.index      <= 8'h00;
      s_r.index_ok   <= 1'b0;
      s_r.rdata      <= 8'h00;
      s_r.rack       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // only power-up restores defaults; hardware reset leaves them
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      cfg_r <= CMU_CFG_POR;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // all outputs straight from flip-flops
  assign io.io_rdata    = s_r.rdata;
  assign io.io_rack     = s_r.rack;
  assign cfg_image      = cfg_r;
  assign config_active  = s_r.cfg_mode;
  assign base_is_alt    = s_r.alt_base;

endmodule
`default_nettype wire

/* File: src/cmu_pkg.sv */
// shared constants and types of the configuration unlock port
package cmu_pkg;

  // i/o bus widths
  localparam int CMU_AW = 16;
  localparam int CMU_DW = 8;

  // port pair decode, primary and alternate base
  localparam logic [15:0] CMU_INDEX_PRI = 16'h03F0;
  localparam logic [15:0] CMU_DATA_PRI  = 16'h03F1;
  localparam logic [15:0] CMU_INDEX_ALT = 16'h0370;
  localparam logic [15:0] CMU_DATA_ALT  = 16'h0371;

  // index-port codes, register count and unclaimed-read value
  localparam logic [7:0] CMU_UNLOCK_CODE = 8'h55;
  localparam logic [7:0] CMU_LOCK_CODE   = 8'hAA;
  localparam logic [7:0] CMU_LAST_REG    = 8'h29;
  localparam logic [7:0] CMU_FLOAT_DATA  = 8'hFF;
  localparam int         CMU_NREG        = 42;

  // host command port, axi4-lite byte offsets
  localparam logic [3:0] CMU_AXI_CMD  = 4'h0;
  localparam logic [3:0] CMU_AXI_STAT = 4'h4;
  localparam int CMU_CMD_ADDR_LSB = 0;
  localparam int CMU_CMD_DATA_LSB = 16;
  localparam int CMU_CMD_OP_LSB   = 24;
  localparam int CMU_STAT_RD_LSB  = 8;
  localparam logic [1:0] CMU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CMU_RESP_SLVERR = 2'h2;

  // host command codes
  localparam logic [1:0] CMU_OP_WRITE  = 2'h0;
  localparam logic [1:0] CMU_OP_READ   = 2'h1;
  localparam logic [1:0] CMU_OP_UNLOCK = 2'h2;
  localparam logic [1:0] CMU_OP_LOCK   = 2'h3;

  // device unlock states
  typedef enum logic [2:0] {
    CMU_LOCKED = 3'h1,
    CMU_ARMED  = 3'h2,
    CMU_CONFIG = 3'h4
  } cmu_dev_state_type;

  // host sequencer states
  typedef enum logic [3:0] {
    CMU_H_IDLE = 4'h1,
    CMU_H_WR   = 4'h2,
    CMU_H_UNL2 = 4'h4,
    CMU_H_RDW  = 4'h8
  } cmu_host_state_type;

  // power-up value of each configuration register
  function automatic logic [7:0] cmu_default(input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      0:  v = 8'h28;
      1:  v = 8'h9C;
      2:  v = 8'h88;
      3:  v = 8'h78;
      6:  v = 8'hFF;
      13: v = 8'h03;
      14: v = 8'h02;
      30: v = 8'h3C;
      32: v = 8'h3C;
      33: v = 8'h3C;
      34: v = 8'h3D;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

endpackage

/* File: src/cmu_io_if.sv */
// i/o bus between host sequencer and configuration port
`timescale 1ns/1ps
`default_nettype none
interface cmu_io_if;
  import cmu_pkg::*;
  logic [CMU_AW-1:0] io_addr;   // port address
  logic              io_wr;     // write strobe, one cycle
  logic              io_rd;     // read strobe, one cycle
  logic [CMU_DW-1:0] io_wdata;  // write data
  logic [CMU_DW-1:0] io_rdata;  // read data
  logic              io_rack;   // read claimed, cycle after io_rd

  modport dev (
    input  io_addr, io_wr, io_rd, io_wdata,
    output io_rdata, io_rack
  );
  modport host (
    output io_addr, io_wr, io_rd, io_wdata,
    input  io_rdata, io_rack
  );
endinterface
`default_nettype wire

/* File: src/cmu_host.sv */
// host sequencer driving the i/o bus from axi4-lite commands
`timescale 1ns/1ps
`default_nettype none
module cmu_host
  import cmu_pkg::*;
(
  input  wire logic        clk_sys,        // bus clock
  input  wire logic        reset_n,        // async reset
  input  wire logic [3:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [3:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  cmu_io_if.host           io              // i/o bus to device
);

  typedef struct packed {
    cmu_host_state_type hs;
    logic               aw_got;
    logic [3:0]         aw_addr;
    logic               w_got;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [15:0]        io_addr;
    logic [7:0]         io_wdata;
    logic               io_wr;
    logic               io_rd;
    logic [7:0]         rd_last;
  } cmu_host_st_type;

  cmu_host_st_type s_r;
  cmu_host_st_type s_nxt;

  always_comb begin
    logic [1:0] op;
    logic       busy;
    op      = s_r.w_data[CMU_CMD_OP_LSB +: 2];
    busy    = s_r.hs != CMU_H_IDLE;
    s_nxt   = s_r;
    s_nxt.io_rd = 1'b0;

    // sequencer: one bus cycle per state, no gaps in an unlock
    unique case (s_r.hs)
      CMU_H_IDLE: s_nxt.io_wr = 1'b0;
      CMU_H_WR: begin
        s_nxt.io_wr = 1'b0;
        s_nxt.hs    = CMU_H_IDLE;
      end
      CMU_H_UNL2: begin
        s_nxt.io_wr = 1'b1;
        s_nxt.hs    = CMU_H_WR;
      end
      CMU_H_RDW: begin
        // the port answers one cycle after the strobe; wait that out
        // first, or the claim is missed and FF latched instead
        if (!s_r.io_rd) begin
          // unclaimed read floats high on a real bus
          s_nxt.rd_last = io.io_rack ? io.io_rdata : CMU_FLOAT_DATA;
          s_nxt.hs      = CMU_H_IDLE;
        end
      end
    endcase

    // write channels taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // both halves present: act and answer
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = CMU_RESP_SLVERR;
      if (s_r.aw_addr == CMU_AXI_CMD && s_r.w_strb == 4'hF && !busy) begin
        s_nxt.bresp    = CMU_RESP_OKAY;
        s_nxt.io_addr  = s_r.w_data[CMU_CMD_ADDR_LSB +: 16];
        s_nxt.io_wdata = s_r.w_data[CMU_CMD_DATA_LSB +: 8];
        unique case (op)
          CMU_OP_WRITE: begin
            s_nxt.io_wr = 1'b1;
            s_nxt.hs    = CMU_H_WR;
          end
          CMU_OP_READ: begin
            s_nxt.io_rd = 1'b1;
            s_nxt.hs    = CMU_H_RDW;
          end
          CMU_OP_UNLOCK: begin
            s_nxt.io_wdata = CMU_UNLOCK_CODE;
            s_nxt.io_wr    = 1'b1;
            s_nxt.hs       = CMU_H_UNL2;
          end
          CMU_OP_LOCK: begin
            s_nxt.io_wdata = CMU_LOCK_CODE;
            s_nxt.io_wr    = 1'b1;
            s_nxt.hs       = CMU_H_WR;
          end
        endcase
      end
    end

    // read channel, one outstanding
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = CMU_RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      if (s_axi_araddr == CMU_AXI_STAT) begin
        s_nxt.rdata[0] = busy;
        s_nxt.rdata[CMU_STAT_RD_LSB +: 8] = s_r.rd_last;
      end else if (s_axi_araddr == CMU_AXI_CMD) begin
        s_nxt.rdata = s_r.w_data;
      end else begin
        s_nxt.rresp = CMU_RESP_SLVERR;
      end
    end

    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r    <= '0;
      s_r.hs <= CMU_H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign io.io_addr    = s_r.io_addr;
  assign io.io_wdata   = s_r.io_wdata;
  assign io.io_wr      = s_r.io_wr;
  assign io.io_rd      = s_r.io_rd;

endmodule
`default_nettype wire

/* File: verif/cmu_asserts.sv */
// concurrent checks on the i/o bus between host and port
`timescale 1ns/1ps
`default_nettype none
module cmu_asserts
  import cmu_pkg::*;
(
  input wire logic        clk_sys,           // bus clock
  input wire logic        reset_n,           // hardware reset
  input wire logic        config_base_strap, // base strap
  input wire logic [15:0] io_addr,           // port address
  input wire logic        io_wr,             // write strobe
  input wire logic        io_rd,             // read strobe
  input wire logic [7:0]  io_wdata,          // write data
  input wire logic        io_rack,           // read claimed
  input wire logic        config_active,     // mode entered
  input wire logic        base_is_alt        // latched strap
);
  logic [15:0] idx_port;
  logic        idx_wr;
  logic        hit55;
  logic        armed_r;
  logic        armed_nxt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // decode of the active index port
  assign idx_port = base_is_alt ? CMU_INDEX_ALT : CMU_INDEX_PRI;
  assign idx_wr   = io_wr && (io_addr == idx_port);
  assign hit55    = idx_wr && (io_wdata == CMU_UNLOCK_CODE);

  // first unlock write seen; any other write breaks it
  always_comb begin
    armed_nxt = armed_r;
    if (io_wr) armed_nxt = hit55 && !config_active;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) armed_r <= 1'b0;
    else armed_r <= armed_nxt;
  end

  unlock_cause_a: assert property (
      $rose(config_active) |-> $past(hit55 && armed_r))
    else $error("mode entered without two unlock writes");
  unlock_enter_a: assert property (
      !config_active && hit55 && armed_r |=> config_active)
    else $error("second unlock write ignored");
  stay_out_a: assert property (
      !config_active && !(hit55 && armed_r) |=> !config_active)
    else $error("mode entered early");
  lock_exit_a: assert property (
      config_active && idx_wr && io_wdata == CMU_LOCK_CODE
      |=> !config_active)
    else $error("lock code did not exit");
  stay_in_a: assert property (
      config_active && !(idx_wr && io_wdata == CMU_LOCK_CODE)
      |=> config_active)
    else $error("mode left without lock code");
  rack_cause_a: assert property (
      io_rack |->
      $past(io_rd && config_active && io_addr == idx_port + 16'h1))
    else $error("read claimed outside mode or port");
  rack_pulse_a: assert property (
      io_rd && config_active && io_addr == idx_port + 16'h1
      |=> io_rack ##1 !io_rack)
    else $error("data read not claimed once");
  strap_latch_a: assert property (
      $past(reset_n) && !$past(reset_n, 2)
      |-> base_is_alt == $past(config_base_strap))
    else $error("strap not latched");
  strap_hold_a: assert property (
      $past(reset_n) && $past(reset_n, 2) |-> $stable(base_is_alt))
    else $error("latched base moved");

  enter_c: cover property ($rose(config_active));
  exit_c: cover property ($fell(config_active));
  rack_c: cover property (io_rack);
endmodule
`default_nettype wire

/* File: verif/config_mode_unlock_port_tb.sv */
// bench: host sequencer and configuration port joined on the i/o bus
`timescale 1ns/1ps
`default_nettype none
module config_mode_unlock_port_tb import cmu_pkg::*;;
  logic                     clk_sys = 1'b0;
  logic                     reset_n, por_n, strap, act, alt;
  logic [3:0]               awa, ara, wst;
  logic [31:0]              wd, rd, s;
  logic                     awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [1:0]               bresp, rresp, r;
  logic [CMU_NREG-1:0][7:0] img;
  logic [7:0]               m [CMU_NREG];
  logic [7:0]               v;
  logic [8:0]               expq [$];
  integer                   seed = 32'h106759AB;
  int                       errors = 0, checks_done = 0, i, k;

  always #12.5 clk_sys = ~clk_sys;

  cmu_io_if io_bus ();
  cmu_dev u_cmu_dev (.clk_sys(clk_sys), .reset_n(reset_n), .por_n(por_n),
    .config_base_strap(strap), .io(io_bus.dev), .cfg_image(img),
    .config_active(act), .base_is_alt(alt));
  cmu_host u_cmu_host (.clk_sys(clk_sys), .reset_n(reset_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .io(io_bus.host));
  cmu_asserts u_cmu_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
    .config_base_strap(strap), .io_addr(io_bus.io_addr),
    .io_wr(io_bus.io_wr), .io_rd(io_bus.io_rd),
    .io_wdata(io_bus.io_wdata), .io_rack(io_bus.io_rack),
    .config_active(act), .base_is_alt(alt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // aw and w offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge clk_sys);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!(bv && br));
    check(bresp, CMU_RESP_OKAY);
    br <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rr));
    d = rd;
    rs = rresp;
    rr <= 1'b0;
  endtask

  // issue one i/o command, then poll busy; polls leave the queue alone
  task automatic cmd(input logic [1:0] op, input logic [15:0] a,
                     input logic [7:0] d);
    axi_wr(CMU_AXI_CMD, {6'h00, op, d, a});
    do begin
      axi_rd(CMU_AXI_STAT, s, r);
    end while (s[0] !== 1'b0);
  endtask

  // port read; the watcher compares the status byte
  task automatic rdreg(input logic [15:0] a, input logic [7:0] e);
    cmd(CMU_OP_READ, a, 8'h00);
    // noted an edge after the last poll, so that poll never takes it
    @(posedge clk_sys);
    expq.push_back({e, 1'b0});
    axi_rd(CMU_AXI_STAT, s, r);
  endtask

  task automatic img_all();
    for (int j = 0; j < CMU_NREG; j++) check(img[j], m[j]);
  endtask

  function automatic logic [7:0] dflt(input int n);
    case (n)
      0: return 8'h28;
      1: return 8'h9C;
      2: return 8'h88;
      3: return 8'h78;
      6: return 8'hFF;
      13: return 8'h03;
      14: return 8'h02;
      30: return 8'h3C;
      32: return 8'h3C;
      33: return 8'h3C;
      34: return 8'h3D;
      default: return 8'h00;
    endcase
  endfunction

  // oldest note against each checked read
  always @(posedge clk_sys) begin
    if (rv && rr && expq.size() > 0) begin
      check({rd[15:8], rd[0]}, expq.pop_front());
    end
  end

  initial begin
    #500000;
    errors++;
    finish_test();
  end

  initial begin
    {reset_n, por_n, strap, awv, wv, br, arv, rr} = 8'h00;
    {awa, ara, wd} = 40'h0;
    wst = 4'hF;
    for (i = 0; i < CMU_NREG; i++) m[i] = dflt(i);
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    img_all();
    check(alt, 1'b0);
    cmd(CMU_OP_WRITE, CMU_DATA_PRI, 8'h5A);
    rdreg(CMU_DATA_PRI, CMU_FLOAT_DATA);
    cmd(CMU_OP_WRITE, CMU_INDEX_PRI, CMU_UNLOCK_CODE);
    cmd(CMU_OP_WRITE, CMU_DATA_PRI, 8'h00);
    cmd(CMU_OP_WRITE, CMU_INDEX_PRI, CMU_UNLOCK_CODE);
    check(act, 1'b0);
    cmd(CMU_OP_UNLOCK, CMU_INDEX_ALT, 8'h00);
    check(act, 1'b0);
    cmd(CMU_OP_UNLOCK, CMU_INDEX_PRI, 8'h00);
    check(act, 1'b1);
    rdreg(CMU_DATA_PRI, CMU_FLOAT_DATA);
    for (i = 0; i < 6; i++) begin
      k = $unsigned($random(seed)) % CMU_NREG;
      v = 8'($random(seed));
      cmd(CMU_OP_WRITE, CMU_INDEX_PRI, k[7:0]);
      cmd(CMU_OP_WRITE, CMU_DATA_PRI, v);
      m[k] = v;
      check(img[k], v);
      rdreg(CMU_DATA_PRI, v);
    end
    cmd(CMU_OP_WRITE, CMU_INDEX_PRI, CMU_LAST_REG + 8'h01);
    cmd(CMU_OP_WRITE, CMU_DATA_PRI, 8'h77);
    rdreg(CMU_DATA_PRI, CMU_FLOAT_DATA);
    cmd(CMU_OP_LOCK, CMU_INDEX_PRI, 8'h00);
    check(act, 1'b0);
    cmd(CMU_OP_WRITE, CMU_DATA_PRI, 8'h11);
    img_all();
    // hardware reset with the alternate base strapped
    @(posedge clk_sys);
    reset_n <= 1'b0;
    strap <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    strap <= 1'b0;
    @(posedge clk_sys);
    check(alt, 1'b1);
    img_all();
    cmd(CMU_OP_UNLOCK, CMU_INDEX_PRI, 8'h00);
    check(act, 1'b0);
    cmd(CMU_OP_UNLOCK, CMU_INDEX_ALT, 8'h00);
    check(act, 1'b1);
    cmd(CMU_OP_WRITE, CMU_INDEX_ALT, 8'h01);
    cmd(CMU_OP_WRITE, CMU_DATA_ALT, 8'hC3);
    check(img[1], 8'hC3);
    rdreg(CMU_DATA_ALT, 8'hC3);
    cmd(CMU_OP_LOCK, CMU_INDEX_ALT, 8'h00);
    check(act, 1'b0);
    axi_rd(4'h8, s, r);
    check(r, CMU_RESP_SLVERR);
    finish_test();
  end
endmodule
`default_nettype wire
